// ---- rtl/sample_packetizer.sv ----
/*
  Packetizer: turns one captured sample record into block begin,
  block item and block end packets on a valid/ready stream.
  Assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module sample_packetizer import sample_trace_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire sample_rec_s rec,
  output logic pkt_valid,
  input wire logic pkt_ready,
  output trace_pkt_s pkt,
  output logic done
);

  logic [2:0] step_q;
  logic valid_q;
  trace_pkt_s pkt_q;

  // group order is fixed here; consumers key on headers anyway
  function automatic trace_pkt_s step_pkt(input logic [2:0] s,
                                          input sample_rec_s r);
    trace_pkt_s p;
    p = '{kind: PKT_BLOCK_ITEM, tag: 8'h00, payload: 64'h0};
    case (s)
      3'h0: p = '{PKT_BLOCK_BEGIN, GRP_BASIC, 64'h0};
      3'h1: p.tag = ITEM_IP;
      3'h2: p.tag = ITEM_TSC;
      3'h3: p = '{PKT_BLOCK_BEGIN, GRP_COUNTER, 64'h0};
      3'h4: p.tag = ITEM_CNT_IDX;
      3'h5: p.tag = ITEM_RELOAD;
      default: p = '{PKT_BLOCK_END, 8'h00, 64'h0};
    endcase
    case (s)
      3'h1: p.payload = r.ip;
      3'h2: p.payload = r.tsc;
      3'h4: p.payload = 64'(r.cnt_idx);
      3'h5: p.payload = r.reload;
      default: p.payload = 64'h0;
    endcase
    return p;
  endfunction : step_pkt

  // no format or size header: the sequence is begin/item/end only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_q <= 3'h0;
      valid_q <= 1'b0;
      pkt_q <= '0;
    end else if (start) begin
      step_q <= 3'h0;
      valid_q <= 1'b1;
      pkt_q <= step_pkt(3'h0, rec);
    end else if (valid_q && pkt_ready) begin
      if (step_q == LAST_STEP) begin
        valid_q <= 1'b0;
      end else begin
        step_q <= step_q + 3'h1;
        pkt_q <= step_pkt(step_q + 3'h1, rec);
      end
    end
  end

  assign pkt_valid = valid_q;
  assign pkt = pkt_q;
  assign done = valid_q && pkt_ready && (step_q == LAST_STEP);

endmodule : sample_packetizer

`default_nettype wire

// ---- rtl/sample_record_trace_output.sv ----
/*
  Sample record router: APB register file, counter overflow sampling,
  routing of each record to the save area port or the trace packet
  stream or dropping it, counter reload and interrupt status.
  Assumes all inputs synchronous to ref_clk; overflow inputs are pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module sample_record_trace_output import sample_trace_pkg::*; #(
  parameter int NUM_GP = NUM_GP_DEF,
  parameter int CNT_W = CNT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_GP-1:0] counter_ovf,
  input wire logic fixed0_ovf,
  input wire logic inst_retired,
  input wire logic [63:0] sample_ip,
  input wire logic [63:0] sample_tsc,
  input wire logic trace_trigger_enable,
  input wire logic trace_context_enable,
  input wire logic trace_filter_enable,
  input wire logic region_full,
  input wire logic save_threshold,
  input wire logic save_overflow,
  input wire logic [CNT_W-1:0] save_reload_value,
  output logic save_valid,
  input wire logic save_ready,
  output sample_rec_s save_rec,
  output logic pkt_valid,
  input wire logic pkt_ready,
  output trace_pkt_s pkt,
  output logic reload_valid,
  output logic [$clog2(NUM_GP+1)-1:0] reload_idx,
  output logic [CNT_W-1:0] reload_value,
  output logic perf_interrupt
);

  localparam int CNT_NUM = NUM_GP + 1;
  localparam int IDX_W = $clog2(CNT_NUM);
  localparam int FIXED0 = NUM_GP;

  typedef enum logic [1:0] {
    S_IDLE,
    S_SAVE,
    S_PKT
  } state_e;

  state_e state_q;
  logic [63:0] sen_q;
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic region_irq_en_q;
  logic ovf_flag_q;
  logic [CNT_W-1:0] reload_q [CNT_NUM];
  logic [CNT_NUM-1:0] pend_q;
  logic fx_arm_q;
  logic [31:0] drop_cnt_q;
  sample_rec_s rec_q;
  logic save_valid_q;
  logic pk_start_q;
  logic reload_valid_q;
  logic [IDX_W-1:0] reload_idx_q;
  logic [CNT_W-1:0] reload_value_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  logic wr_en;
  logic rd_setup;
  logic [1:0] out_sel;
  logic save_mode;
  logic trace_mode;
  logic [CNT_NUM-1:0] pend_set;
  logic [CNT_NUM-1:0] take_vec;
  logic [IDX_W-1:0] pick;
  logic take;
  logic rec_done;
  logic pk_done;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] rd_d;
  logic err_d;

  function automatic logic rl_hit(input logic [11:0] a);
    return (a >= RELOAD_BASE) && (a < RELOAD_BASE + 12'(8 * CNT_NUM));
  endfunction : rl_hit

  function automatic logic [IDX_W-1:0] rl_idx(input logic [11:0] a);
    logic [11:0] d;
    d = (a - RELOAD_BASE) >> 3;
    return d[IDX_W-1:0];
  endfunction : rl_idx

  // lowest index first; a steady overflow on one counter can starve
  // higher ones only if it retriggers faster than a record drains
  function automatic logic [IDX_W-1:0] first_set(
      input logic [CNT_NUM-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = CNT_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : first_set

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign out_sel = sen_q[SEL_MSB:SEL_LSB];
  assign save_mode = (out_sel == SEL_SAVE);
  assign trace_mode = (out_sel == SEL_TRACE);

  // register bus: data latched in setup, answered in the first access
  always_comb begin
    logic [63:0] rl_word;
    rl_word = 64'(reload_q[rl_idx(paddr)]);
    rd_d = 32'h0;
    err_d = 1'b0;
    case (paddr)
      OFF_SEN_LO: rd_d = sen_q[31:0];
      OFF_SEN_HI: rd_d = sen_q[63:32];
      OFF_CAP: rd_d = CAP_VALUE;
      OFF_TRACE_CFG: rd_d = {31'h0, region_irq_en_q};
      // context and filter only mirrored, never used
      OFF_TRACE_STS: rd_d = {29'h0, trace_filter_enable,
                             trace_context_enable, trace_trigger_enable};
      OFF_GSTATUS: rd_d = {31'h0, ovf_flag_q};
      OFF_IRQ_STS: rd_d = 32'(irq_sts_q);
      OFF_IRQ_MASK: rd_d = 32'(irq_mask_q);
      OFF_STATE: rd_d = {14'h0, fx_arm_q, 15'(pend_q), 2'(state_q)};
      OFF_DROPS: rd_d = drop_cnt_q;
      default: begin
        if (rl_hit(paddr)) begin
          rd_d = paddr[2] ? rl_word[63:32] : rl_word[31:0];
        end else begin
          err_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (rd_setup) begin
      prdata_q <= pwrite ? 32'h0 : rd_d;
      pslverr_q <= err_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  // config registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sen_q <= SEN_RST;
      irq_mask_q <= IRQ_RST;
      region_irq_en_q <= 1'b0;
    end else if (wr_en && !pslverr_q) begin
      case (paddr)
        OFF_SEN_LO: sen_q[31:0] <= pwdata;
        OFF_SEN_HI: sen_q[63:32] <= pwdata;
        OFF_TRACE_CFG: region_irq_en_q <= pwdata[0];
        OFF_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // reload registers, one per counter, two words each
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CNT_NUM; i++) begin
        reload_q[i] <= '0;
      end
    end else if (wr_en && rl_hit(paddr)) begin
      logic [63:0] w;
      w = 64'(reload_q[rl_idx(paddr)]);
      if (paddr[2]) begin
        w[63:32] = pwdata;
      end else begin
        w[31:0] = pwdata;
      end
      reload_q[rl_idx(paddr)] <= w[CNT_W-1:0];
    end
  end

  // overflow capture; general counters sample at once (counter zero
  // keeps its reduced-skid path this way)
  genvar g;
  generate
    for (g = 0; g < NUM_GP; g++) begin : gp_pend
      assign pend_set[g] = counter_ovf[g] && sen_q[g];
    end
  endgenerate
  // fixed counter 0 samples at the next retired instruction
  assign pend_set[FIXED0] = fx_arm_q && inst_retired;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fx_arm_q <= 1'b0;
    end else if (fixed0_ovf && sen_q[FIXED0_EN_BIT]) begin
      fx_arm_q <= 1'b1;
    end else if (inst_retired) begin
      fx_arm_q <= 1'b0;
    end
  end

  assign take = (state_q == S_IDLE) && (|pend_q);
  assign pick = first_set(pend_q);
  assign take_vec = take ? (CNT_NUM'(1) << pick) : '0;

  // new overflow wins over the clear of a taken request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~take_vec) | pend_set;
    end
  end

  // reload on every trigger, whatever the route or trigger enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_valid_q <= 1'b0;
      reload_idx_q <= '0;
      reload_value_q <= '0;
    end else begin
      reload_valid_q <= take;
      if (take) begin
        reload_idx_q <= pick;
        // save mode takes its value from the save area side
        reload_value_q <= save_mode ? save_reload_value
                                    : reload_q[pick];
      end
    end
  end

  assign reload_valid = reload_valid_q;
  assign reload_idx = reload_idx_q;
  assign reload_value = reload_value_q;

  // routing state machine
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      rec_q <= '0;
      save_valid_q <= 1'b0;
      pk_start_q <= 1'b0;
      drop_cnt_q <= DROPS_RST;
    end else begin
      pk_start_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (take) begin
            rec_q <= '{ip: sample_ip, tsc: sample_tsc,
                       cnt_idx: 8'(pick),
                       reload: 64'(save_mode ? save_reload_value
                                             : reload_q[pick])};
            if (save_mode) begin
              state_q <= S_SAVE;
              save_valid_q <= 1'b1;
            end else if (trace_mode && trace_trigger_enable) begin
              state_q <= S_PKT;
              pk_start_q <= 1'b1;
            end else begin
              // trigger off or reserved selector: record dropped
              drop_cnt_q <= drop_cnt_q + 32'h1;
            end
          end
        end
        S_SAVE: begin
          if (save_ready) begin
            save_valid_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_PKT: begin
          if (pk_done) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign save_valid = save_valid_q;
  assign save_rec = rec_q;

  sample_packetizer sample_packetizer_inst (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(pk_start_q),
    .rec(rec_q),
    .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready),
    .pkt(pkt),
    .done(pk_done)
  );

  assign rec_done = ((state_q == S_SAVE) && save_ready)
                 || ((state_q == S_PKT) && pk_done);

  // interrupt sources
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_RECORD] = rec_done && sen_q[SEN_IRQ_BIT];
    irq_set[IRQ_THRESH] = save_threshold && save_mode;
    irq_set[IRQ_REGION] = region_full && region_irq_en_q
                          && trace_mode;
  end

  assign irq_clr = (wr_en && paddr == OFF_IRQ_STS) ? pwdata[IRQ_W-1:0]
                                                   : '0;

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_sts_q <= IRQ_RST;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_flag_q <= 1'b0;
    end else if (save_overflow && save_mode) begin
      ovf_flag_q <= 1'b1;
    end else if (wr_en && paddr == OFF_GSTATUS && pwdata[0]) begin
      ovf_flag_q <= 1'b0;
    end
  end

  assign perf_interrupt = |(irq_sts_q & irq_mask_q);

endmodule : sample_record_trace_output

`default_nettype wire

// ---- rtl/sample_trace_pkg.sv ----
/*
  Shared constants and types for the sample record router: register
  offsets, field positions, reset values, packet and record carriers.
  Assumes a 32-bit APB register bus with a 12-bit byte address.
*/
`default_nettype none
package sample_trace_pkg;

  localparam int NUM_GP_DEF = 4;
  localparam int CNT_W_DEF = 48;

  localparam logic [11:0] OFF_SEN_LO = 12'h000;
  localparam logic [11:0] OFF_SEN_HI = 12'h004;
  localparam logic [11:0] OFF_CAP = 12'h008;
  localparam logic [11:0] OFF_TRACE_CFG = 12'h00C;
  localparam logic [11:0] OFF_TRACE_STS = 12'h010;
  localparam logic [11:0] OFF_GSTATUS = 12'h014;
  localparam logic [11:0] OFF_IRQ_STS = 12'h018;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
  localparam logic [11:0] OFF_STATE = 12'h020;
  localparam logic [11:0] OFF_DROPS = 12'h024;
  localparam logic [11:0] RELOAD_BASE = 12'h040;

  // sampling enable register fields (64-bit view)
  localparam int FIXED0_EN_BIT = 32;
  localparam int SEN_IRQ_BIT = 60;
  localparam int SEL_LSB = 61;
  localparam int SEL_MSB = 62;
  localparam logic [1:0] SEL_SAVE = 2'h0;
  localparam logic [1:0] SEL_TRACE = 2'h1;

  localparam int CAP_TRACE_OUT_BIT = 16;
  localparam logic [31:0] CAP_VALUE = 32'h0001_0000;

  localparam int IRQ_RECORD = 0;
  localparam int IRQ_THRESH = 1;
  localparam int IRQ_REGION = 2;
  localparam int IRQ_W = 3;

  localparam logic [63:0] SEN_RST = 64'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic [31:0] DROPS_RST = 32'h0;

  localparam logic [7:0] GRP_BASIC = 8'h01;
  localparam logic [7:0] GRP_COUNTER = 8'h02;
  localparam logic [7:0] ITEM_IP = 8'h01;
  localparam logic [7:0] ITEM_TSC = 8'h02;
  localparam logic [7:0] ITEM_CNT_IDX = 8'h03;
  localparam logic [7:0] ITEM_RELOAD = 8'h04;
  localparam logic [2:0] LAST_STEP = 3'h6;

  typedef enum logic [1:0] {
    PKT_BLOCK_BEGIN,
    PKT_BLOCK_ITEM,
    PKT_BLOCK_END
  } pkt_kind_e;

  typedef struct packed {
    pkt_kind_e kind;
    logic [7:0] tag;
    logic [63:0] payload;
  } trace_pkt_s;

  typedef struct packed {
    logic [63:0] ip;
    logic [63:0] tsc;
    logic [7:0] cnt_idx;
    logic [63:0] reload;
  } sample_rec_s;

endpackage : sample_trace_pkg

`default_nettype wire

// ---- sim/sample_record_trace_output_sva.sv ----
/*
  Port checker for the sample record router.
  Assumes ref_clk domain only; bound to every router instance.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_record_trace_output_chk import sample_trace_pkg::*; #(
  parameter int NUM_GP = NUM_GP_DEF,
  parameter int CNT_W = CNT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trace_trigger_enable,
  input wire logic save_valid,
  input wire logic save_ready,
  input wire sample_rec_s save_rec,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire trace_pkt_s pkt,
  input wire logic reload_valid,
  input wire logic [$clog2(NUM_GP+1)-1:0] reload_idx
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_CAP_BIT: assert property (psel && penable && !pwrite &&
    paddr == OFF_CAP |-> prdata[CAP_TRACE_OUT_BIT] && pready)
    else $error("capability bit missing");
  AST_BEGIN_FIRST: assert property ($rose(pkt_valid) |->
    pkt.kind == PKT_BLOCK_BEGIN) else $error("group not opened");
  AST_END_LAST: assert property (pkt_valid && pkt_ready &&
    pkt.kind == PKT_BLOCK_END |=> !pkt_valid)
    else $error("packet after end");
  AST_PKT_HOLD: assert property (pkt_valid && !pkt_ready |=>
    pkt_valid && $stable(pkt)) else $error("packet dropped");
  // trigger enable is sampled at the take, two edges before valid rises
  AST_TRIG_DROP: assert property ($rose(pkt_valid) |->
    $past(trace_trigger_enable, 2)) else $error("record not dropped");
  AST_ONE_DEST: assert property (!(save_valid && pkt_valid))
    else $error("two destinations");
  AST_SAVE_HOLD: assert property (save_valid && !save_ready |=>
    save_valid && $stable(save_rec)) else $error("save record lost");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  AST_IDX: assert property (reload_valid |->
    reload_idx <= NUM_GP) else $error("bad reload index");
  COV_END: cover property (pkt_valid && pkt_ready &&
    pkt.kind == PKT_BLOCK_END);
  COV_SAVE: cover property (save_valid && save_ready);
  COV_FIX: cover property (reload_valid && reload_idx == NUM_GP);
endmodule : sample_record_trace_output_chk
bind sample_record_trace_output sample_record_trace_output_chk #(
  .NUM_GP(NUM_GP), .CNT_W(CNT_W)) chk_inst (.ref_clk, .arst_n,
  .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .trace_trigger_enable, .save_valid, .save_ready, .save_rec,
  .pkt_valid, .pkt_ready, .pkt, .reload_valid, .reload_idx);
`default_nettype wire

// ---- sim/sample_record_trace_output_tb.sv ----
/*
  Self-checking bench for the sample record router.
  Assumes the trace_sink model on the far side and a bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_record_trace_output_tb;
  import sample_trace_pkg::*;
  localparam int NG = 4;
  logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, fixed0_ovf = 0, inst_retired = 0, slow = 0;
  logic [NG-1:0] counter_ovf = '0;
  logic [63:0] sample_ip = '0, sample_tsc = '0;
  logic trig = 1, ctx = 1, filt = 1, region_full = 0;
  logic save_threshold = 0, save_overflow = 0;
  logic [47:0] save_reload_value = '0, reload_value;
  logic save_valid, save_ready, pkt_valid, pkt_ready, reload_valid;
  logic perf_interrupt;
  logic [2:0] reload_idx;
  sample_rec_s save_rec;
  trace_pkt_s pkt;
  logic [47:0] rv [NG+1], srv;
  int fails = 0, n_tests = 0, cyc = 0, i;
  pkt_kind_e kinds [7] = '{PKT_BLOCK_BEGIN, PKT_BLOCK_ITEM,
    PKT_BLOCK_ITEM, PKT_BLOCK_BEGIN, PKT_BLOCK_ITEM, PKT_BLOCK_ITEM,
    PKT_BLOCK_END};
  logic [7:0] tags [6] = '{GRP_BASIC, ITEM_IP, ITEM_TSC, GRP_COUNTER,
    ITEM_CNT_IDX, ITEM_RELOAD};

  sample_record_trace_output #(.NUM_GP(NG), .CNT_W(48))
    sample_record_trace_output_inst (.ref_clk, .arst_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .counter_ovf,
    .fixed0_ovf, .inst_retired, .sample_ip, .sample_tsc,
    .trace_trigger_enable(trig), .trace_context_enable(ctx),
    .trace_filter_enable(filt), .region_full, .save_threshold,
    .save_overflow, .save_reload_value, .save_valid, .save_ready,
    .save_rec, .pkt_valid, .pkt_ready, .pkt, .reload_valid, .reload_idx,
    .reload_value, .perf_interrupt);
  trace_sink trace_sink_inst (.ref_clk, .arst_n, .slow, .pkt_valid,
    .pkt_ready, .pkt, .save_valid, .save_ready, .save_rec);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [32:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    logic [32:0] r;
    apb(1'b0, a, '0, r);
    chk(r, x);
  endtask : rd
  function automatic logic [31:0] hi(input logic [1:0] s);
    return 32'h1000_0001 | {1'b0, s, 29'h0};
  endfunction : hi
  task automatic pulse3;
    @(posedge ref_clk);
    {save_threshold, save_overflow, region_full} <= 3'h7;
    @(posedge ref_clk);
    {save_threshold, save_overflow, region_full} <= 3'h0;
    @(negedge ref_clk);
  endtask : pulse3

  // one sample on counter i (NG is fixed counter 0); np packets, ns saves
  task automatic fire(input int i, input logic [47:0] xv, input int np,
    input int ns);
    int k, p0, s0;
    logic [63:0] ip, ts;
    p0 = trace_sink_inst.got.size();
    s0 = trace_sink_inst.n_save;
    ip = {$urandom, $urandom};
    ts = {$urandom, $urandom};
    slow <= 1'($urandom_range(1));
    sample_ip <= ip;
    sample_tsc <= ts;
    @(posedge ref_clk);
    counter_ovf <= NG'(1) << i;
    fixed0_ovf <= (i == NG);
    @(posedge ref_clk);
    counter_ovf <= '0;
    fixed0_ovf <= 1'b0;
    // fixed counter samples on the next retiring instruction
    inst_retired <= (i == NG);
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      inst_retired <= 1'b0;
      #1;
      if (reload_valid === 1'b1) break;
    end
    chk({reload_valid, reload_idx, reload_value},
        {1'b1, 3'(i), xv});
    // a stalling sink may hold off the save handshake for many cycles
    for (k = 0; k < 99 && (trace_sink_inst.got.size() < p0 + np ||
         trace_sink_inst.n_save < s0 + ns); k++)
      @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk(trace_sink_inst.got.size() - p0, np);
    chk(trace_sink_inst.n_save - s0, ns);
    if (ns == 1) chk(trace_sink_inst.last_save.ip, ip);
    for (k = 0; k < np; k++) begin
      chk(trace_sink_inst.got[p0+k].kind, kinds[k]);
      if (k < 6) chk(trace_sink_inst.got[p0+k].tag, tags[k]);
    end
    if (np == 7) chk(trace_sink_inst.got[p0+1].payload, ip);
    if (np == 7) chk(trace_sink_inst.got[p0+2].payload, ts);
  endtask : fire

  initial begin
    void'($urandom(72));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(OFF_SEN_HI, 33'h0);
    rd(OFF_IRQ_STS, 33'h0);
    wr(OFF_CAP, 32'h0);
    rd(OFF_CAP, {1'b0, CAP_VALUE});
    rd(12'h030, 33'h1_0000_0000);
    for (i = 0; i <= NG; i++) begin
      rv[i] = 48'({$urandom, $urandom});
      wr(RELOAD_BASE + 12'(8 * i), rv[i][31:0]);
      wr(RELOAD_BASE + 12'(8 * i + 4), {16'h0, rv[i][47:32]});
    end
    wr(OFF_SEN_LO, 32'hF);
    wr(OFF_SEN_HI, hi(SEL_TRACE));
    wr(OFF_IRQ_MASK, 32'h7);
    wr(OFF_TRACE_CFG, 32'h1);
    fire(0, rv[0], 7, 0);
    fire(NG, rv[NG], 7, 0);
    for (int n = 0; n < 6; n++) begin
      i = $urandom_range(NG);
      {ctx, filt} <= 2'($urandom);
      fire(i, rv[i], 7, 0);
    end
    rd(OFF_IRQ_STS, 33'h1);
    chk(perf_interrupt, 1'b1);
    wr(OFF_IRQ_MASK, 32'h6);
    @(negedge ref_clk);
    chk(perf_interrupt, 1'b0);
    wr(OFF_IRQ_STS, 32'h1);
    wr(OFF_IRQ_MASK, 32'h7);
    trig <= 1'b0;
    fire(1, rv[1], 0, 0);
    rd(OFF_IRQ_STS, 33'h0);
    pulse3();
    rd(OFF_IRQ_STS, 33'h4);
    rd(OFF_GSTATUS, 33'h0);
    wr(OFF_IRQ_STS, 32'h7);
    trig <= 1'b1;
    wr(OFF_SEN_HI, hi(2'h2));
    fire(2, rv[2], 0, 0);
    wr(OFF_SEN_HI, hi(2'h3));
    fire(3, rv[3], 0, 0);
    rd(OFF_DROPS, 33'h3);
    wr(OFF_SEN_HI, hi(SEL_SAVE));
    // expected value kept apart: the input only updates after the call
    srv = 48'({$urandom, $urandom});
    save_reload_value <= srv;
    fire(3, srv, 0, 1);
    pulse3();
    rd(OFF_GSTATUS, 33'h1);
    wr(OFF_GSTATUS, 32'h1);
    rd(OFF_GSTATUS, 33'h0);
    rd(OFF_IRQ_STS, 33'h3);
    wr(OFF_IRQ_STS, 32'h7);
    rd(OFF_IRQ_STS, 33'h0);
    stop_test();
  end
endmodule : sample_record_trace_output_tb
`default_nettype wire

// ---- sim/trace_sink.sv ----
/*
  Far-side model: trace packet output unit and save area writer.
  Assumes valid/ready streams on ref_clk; slow makes it stall at random.
*/
`timescale 1ns/1ps
`default_nettype none
module trace_sink import sample_trace_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire trace_pkt_s pkt,
  input wire logic save_valid,
  output logic save_ready,
  input wire sample_rec_s save_rec
);
  trace_pkt_s got[$];
  sample_rec_s last_save;
  int n_save = 0;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pkt_ready <= 1'b0;
      save_ready <= 1'b0;
    end else begin
      pkt_ready <= !slow || $urandom_range(1) == 1;
      save_ready <= !slow || $urandom_range(1) == 1;
    end
  end
  // packets are kept in arrival order; the bench checks them by position
  always @(posedge ref_clk) begin
    if (pkt_valid && pkt_ready) got.push_back(pkt);
    if (save_valid && save_ready) begin
      n_save++;
      last_save = save_rec;
    end
  end
endmodule : trace_sink
`default_nettype wire
